//--- rtl/physical_rng_health_gate.sv
// health tests and output gate between raw entropy bits and octets
// =========================================================
// Overview of operation
// - startup total-failure check blocks all output
// - failure in operation discards pending and later octets
// - online test at start and throughout operation
// - no output before startup pass or after defect
// - online test runs continuously on every raw bit
// - random output delivered as eight-bit octets
// - window bounds reject low-entropy raw sequences
// - octets are raw samples, no post-processing
`timescale 1ns/10ps
`default_nettype none

module physical_rng_health_gate
  import rng_gate_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic raw_bit,
  input wire logic raw_bit_valid,
  output logic [OCTET_W-1:0] octet_data,
  output logic octet_valid,
  input wire logic octet_ready,
  output health_status_t status
);

  // =========================================================
  // state
  gate_state_t state_q, state_d;
  logic last_bit_q;
  logic [RUN_W-1:0] run_cnt_q, run_cnt_d;
  logic [WIN_W-1:0] win_cnt_q, win_cnt_d;
  logic [ONES_W-1:0] ones_cnt_q, ones_cnt_d;
  logic [OCTET_W-1:0] shift_q;
  logic [2:0] bit_cnt_q;
  logic [OCTET_W-1:0] out_q;
  logic out_valid_q, out_valid_d;
  logic tf_seen_q, sf_seen_q;

  // =========================================================
  // total-failure test: stuck source repeats one value
  wire same_bit = raw_bit == last_bit_q;
  wire total_fail = raw_bit_valid && same_bit &&
                    (run_cnt_q == TF_RUN_LIMIT - RUN_ONE);
  wire run_sat = run_cnt_q == RUN_MAX;
  assign run_cnt_d = !raw_bit_valid ? run_cnt_q :
                     !same_bit ? RUN_ONE :
                     run_sat ? run_cnt_q : run_cnt_q + RUN_ONE;

  // =========================================================
  // online test: ones count per window of raw bits
  wire win_end = raw_bit_valid && (win_cnt_q == WIN_LAST);
  wire [ONES_W-1:0] ones_final = ones_cnt_q + {8'h00, raw_bit};
  wire ones_bad = (ones_final < ONES_MIN) ||
                  (ones_final > ONES_MAX);
  wire stat_fail = win_end && ones_bad;
  wire any_fail = total_fail || stat_fail;
  assign win_cnt_d = raw_bit_valid ? win_cnt_q + 8'h01 : win_cnt_q;
  assign ones_cnt_d = !raw_bit_valid ? ones_cnt_q :
                      win_end ? ONES_RST : ones_final;

  // =========================================================
  // gate state machine
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_STARTUP:
      begin
        if (any_fail)
          state_d = ST_FAIL;
        else if (win_end)
          state_d = ST_RUN;
      end
      ST_RUN:
      begin
        if (any_fail)
          state_d = ST_FAIL;
      end
      ST_FAIL:
        state_d = ST_FAIL;
      default:
        state_d = ST_FAIL;
    endcase
  end

  // =========================================================
  // octet assembly and output register
  wire octet_done = raw_bit_valid && (bit_cnt_q == BIT_LAST);
  wire [OCTET_W-1:0] octet_next = {shift_q[OCTET_W-2:0], raw_bit};
  wire in_run = state_q == ST_RUN;
  wire out_free = !out_valid_q || octet_ready;
  wire load = octet_done && in_run && !any_fail && out_free;
  assign out_valid_d = any_fail ? 1'b0 :
                       load ? 1'b1 :
                       octet_ready ? 1'b0 : out_valid_q;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ST_STARTUP;
      last_bit_q <= 1'b0;
      run_cnt_q <= RUN_RST;
      win_cnt_q <= WIN_RST;
      ones_cnt_q <= ONES_RST;
      shift_q <= OCTET_RST;
      bit_cnt_q <= BIT_RST;
      out_q <= OCTET_RST;
      out_valid_q <= 1'b0;
      tf_seen_q <= 1'b0;
      sf_seen_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      run_cnt_q <= run_cnt_d;
      win_cnt_q <= win_cnt_d;
      ones_cnt_q <= ones_cnt_d;
      out_valid_q <= out_valid_d;
      tf_seen_q <= tf_seen_q || total_fail;
      sf_seen_q <= sf_seen_q || stat_fail;
      if (raw_bit_valid)
      begin
        last_bit_q <= raw_bit;
        shift_q <= octet_next;
        bit_cnt_q <= bit_cnt_q + 3'h1;
      end
      if (load)
        out_q <= octet_next;
    end
  end

  // =========================================================
  // outputs
  assign octet_data = out_q;
  assign octet_valid = out_valid_q && in_run;
  assign status = health_status_t'{
    failed: state_q == ST_FAIL,
    total_fail_seen: tf_seen_q,
    stat_fail_seen: sf_seen_q,
    startup_done: state_q != ST_STARTUP
  };

  // =========================================================
  // assertions
  a_no_early_out: assert property (@(posedge core_clk) disable iff (!rstn)
    (state_q == ST_STARTUP) |-> !octet_valid && !out_valid_q)
    else $error("octet offered before startup test passed");

  a_total_fail_block: assert property (@(posedge core_clk)
    disable iff (!rstn)
    total_fail |=> (status.failed && !octet_valid) [*3])
    else $error("total failure did not block output");

  a_run_fail_drop: assert property (@(posedge core_clk) disable iff (!rstn)
    (in_run && total_fail) |=> !out_valid_q)
    else $error("pending octet survived a total failure");

  a_stat_fail_flag: assert property (@(posedge core_clk) disable iff (!rstn)
    stat_fail |=> status.failed && status.stat_fail_seen)
    else $error("online test defect not flagged");

  a_startup_exit: assert property (@(posedge core_clk) disable iff (!rstn)
    (state_q == ST_STARTUP && win_end && !any_fail) |=>
    state_q == ST_RUN)
    else $error("startup did not end after a clean window");

  a_win_counts: assert property (@(posedge core_clk) disable iff (!rstn)
    raw_bit_valid |=> win_cnt_q == $past(win_cnt_q) + 8'h01)
    else $error("online test skipped a raw bit");

  a_octet_raw: assert property (@(posedge core_clk) disable iff (!rstn)
    load |=> octet_data == {$past(shift_q[6:0]), $past(raw_bit)})
    else $error("octet differs from raw samples");

  a_octet_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    (octet_valid && !octet_ready && !any_fail) |=>
    octet_valid && $stable(octet_data))
    else $error("offered octet changed before taken");

  a_fail_sticky: assert property (@(posedge core_clk) disable iff (!rstn)
    status.failed |=> status.failed && !octet_valid)
    else $error("failure flag cleared without reset");

  a_tf_flag_set: assert property (@(posedge core_clk) disable iff (!rstn)
    total_fail |=> status.total_fail_seen)
    else $error("total failure not recorded in status");

  a_run_restart: assert property (@(posedge core_clk) disable iff (!rstn)
    (raw_bit_valid && !same_bit) |=> run_cnt_q == RUN_ONE)
    else $error("repeat run not restarted on a changed bit");

  a_window_restart: assert property (@(posedge core_clk) disable iff (!rstn)
    win_end |=> ones_cnt_q == ONES_RST)
    else $error("ones count not cleared at window end");

  a_taken_drop: assert property (@(posedge core_clk) disable iff (!rstn)
    (octet_valid && octet_ready && !load) |=> !octet_valid)
    else $error("taken octet offered a second time");

  a_load_offer: assert property (@(posedge core_clk) disable iff (!rstn)
    load |=> octet_valid)
    else $error("loaded octet not offered");

  a_idle_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    !raw_bit_valid |=> $stable(run_cnt_q) && $stable(win_cnt_q))
    else $error("health counters moved without a raw bit");

  // =========================================================
  // cover points
  c_reach_run: cover property (@(posedge core_clk) disable iff (!rstn)
    state_q == ST_STARTUP ##1 state_q == ST_RUN);
  c_octet_taken: cover property (@(posedge core_clk) disable iff (!rstn)
    octet_valid && octet_ready);
  c_tf_in_run: cover property (@(posedge core_clk) disable iff (!rstn)
    in_run && total_fail);
  c_stat_fail: cover property (@(posedge core_clk) disable iff (!rstn)
    stat_fail);
  c_octet_waits: cover property (@(posedge core_clk) disable iff (!rstn)
    octet_valid && !octet_ready);

endmodule // physical_rng_health_gate

`default_nettype wire

//--- rtl/rng_gate_pkg.sv
// constants and types shared by the random octet health gate
package rng_gate_pkg;

  // =========================================================
  // total-failure test
  localparam int unsigned RUN_W = 6;
  localparam logic [RUN_W-1:0] TF_RUN_LIMIT = 6'h20;
  localparam logic [RUN_W-1:0] RUN_ONE = 6'h01;
  localparam logic [RUN_W-1:0] RUN_MAX = 6'h3f;

  // =========================================================
  // online statistical test, one window of raw bits
  localparam int unsigned WIN_W = 8;
  localparam logic [WIN_W-1:0] WIN_LAST = 8'hff;
  localparam int unsigned ONES_W = 9;
  localparam logic [ONES_W-1:0] ONES_MIN = 9'h060;
  localparam logic [ONES_W-1:0] ONES_MAX = 9'h0a0;

  // =========================================================
  // octet assembly
  localparam int unsigned OCTET_W = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // =========================================================
  // reset values
  localparam logic [OCTET_W-1:0] OCTET_RST = 8'h00;
  localparam logic [RUN_W-1:0] RUN_RST = 6'h00;
  localparam logic [WIN_W-1:0] WIN_RST = 8'h00;
  localparam logic [ONES_W-1:0] ONES_RST = 9'h000;
  localparam logic [2:0] BIT_RST = 3'h0;

  typedef enum logic [1:0] {
    ST_STARTUP = 2'b00,
    ST_RUN     = 2'b01,
    ST_FAIL    = 2'b10
  } gate_state_t;

  typedef struct packed {
    logic failed;
    logic total_fail_seen;
    logic stat_fail_seen;
    logic startup_done;
  } health_status_t;

endpackage

//--- test/rng_consumer_model.sv
// consumer model that takes random octets
`timescale 1ns/10ps
`default_nettype none

module rng_consumer_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic octet_valid,
  output logic octet_ready
);
  // =========================================================
  // takes only offered octets, one cycle late when slow
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      octet_ready <= 1'b0;
    else
      octet_ready <= slow ? (octet_valid & !octet_ready) : 1'b1;
  end
endmodule // rng_consumer_model

`default_nettype wire

//--- test/physical_rng_health_gate_tb_top.sv
// self-checking bench for the random octet health gate
`timescale 1ns/10ps
`default_nettype none

module physical_rng_health_gate_tb_top;
  import rng_gate_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic raw_bit = 1'b0;
  logic raw_bit_valid = 1'b0;
  logic slow = 1'b0;
  logic octet_ready;
  logic octet_valid;
  logic [OCTET_W-1:0] octet_data;
  health_status_t status;
  int num_errors = 0;
  int samples_checked = 0;
  integer seed = 61;
  int cyc = 0;
  int mode = 0;
  int i, st, cnt, ones, run;
  logic tf, sf, b;
  logic [31:0] r;
  logic [7:0] sr;
  logic [7:0] exp_q[$];

  // =========================================================
  // clock, design and consumer
  always #5 core_clk = ~core_clk;
  physical_rng_health_gate i_dut (.core_clk(core_clk), .rstn(rstn),
    .raw_bit(raw_bit), .raw_bit_valid(raw_bit_valid),
    .octet_data(octet_data), .octet_valid(octet_valid),
    .octet_ready(octet_ready), .status(status));
  rng_consumer_model i_cons (.core_clk(core_clk), .rstn(rstn),
    .slow(slow), .octet_valid(octet_valid), .octet_ready(octet_ready));

  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task give_verdict;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // =========================================================
  // reference model, checks and stimulus for the coming edge
  always @(negedge core_clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      num_errors++;
      give_verdict();
    end
    if (!rstn)
    begin
      st = 0;
      cnt = 0;
      ones = 0;
      run = 0;
      tf = 1'b0;
      sf = 1'b0;
      i = 0;
      exp_q = {};
    end
    else
    begin
      if (raw_bit_valid)
      begin
        sr = {sr[6:0], raw_bit};
        run = (cnt > 0 && raw_bit == sr[1]) ? run + 1 : 1;
        ones += raw_bit;
        tf |= (run == 32);
        sf |= (cnt % 256 == 255 && (ones < 96 || ones > 160));
        if (cnt % 8 == 7 && st == 1 && !tf && !sf)
          exp_q.push_back(sr);
        if (tf || sf)
        begin
          st = 2;
          exp_q = {};
        end
        else if (cnt % 256 == 255)
          st = 1;
        if (cnt % 256 == 255)
          ones = 0;
        cnt++;
      end
      chk("status", {4'h0, st == 2, tf, sf, st != 0}, {4'h0, status});
      if (st != 1)
        chk("octet_valid", 8'h00, {7'h00, octet_valid});
      if (octet_valid && octet_ready && exp_q.size() == 0)
        chk("extra_octet", 8'h00, 8'h01);
      else if (octet_valid && octet_ready)
        chk("octet_data", exp_q.pop_front(), octet_data);
      chk("backlog", 8'h01, {7'h00, exp_q.size() < 2});
    end
    r = $random(seed);
    b = r[0];
    if (mode == 2 && i >= 600 && i < 640)
      b = 1'b1;
    if (mode == 3)
      b = (i % 5 != 0);
    if (mode == 4 && i < 40)
      b = 1'b0;
    raw_bit <= b;
    raw_bit_valid <= rstn && r[3:2] != 2'h0;
    if (rstn && r[3:2] != 2'h0)
      i++;
  end

  // =========================================================
  // modes: random, slow consumer, late, statistical, early failure
  initial
  begin
    for (int m = 0; m < 5; m++)
    begin
      mode <= m;
      slow <= (m == 1);
      rstn <= 1'b0;
      repeat (2) @(negedge core_clk);
      rstn <= 1'b1;
      repeat (1500) @(negedge core_clk);
    end
    give_verdict();
  end
endmodule // physical_rng_health_gate_tb_top

`default_nettype wire
